/* File: hw/csp_pkg.sv */
package csp_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] CHG_CTL_ADDR = 8'h01;
   localparam logic [7:0] SUPV_ADDR = 8'h02;
   localparam logic [7:0] ILIM_ADDR = 8'h03;

   // charge control layout and reset
   localparam int TERM_LSB = 6;
   localparam int ICC_LSB = 2;
   localparam int CHG_EN_BIT = 1;
   localparam logic [7:0] CHG_CTL_RST = 8'h47;

   // supervisor layout and reset
   localparam int LED_CUR_BIT = 5;
   localparam int LED_EN_BIT = 4;
   localparam int TEMP_WIN_BIT = 3;
   localparam logic LED_CUR_RST = 1'h1;
   localparam logic LED_EN_RST = 1'h1;
   localparam logic TEMP_WIN_RST = 1'h0;

   // current limit field
   localparam logic [1:0] ILIM_RST = 2'h0;
   localparam logic [1:0] ILIM_PIN = 2'h0;
   localparam logic [1:0] ILIM_100 = 2'h1;
   localparam logic [1:0] ILIM_500 = 2'h2;
   localparam logic [1:0] ILIM_800 = 2'h3;

   // termination voltage codes
   localparam logic [1:0] TERM_410 = 2'h0;
   localparam logic [1:0] TERM_420 = 2'h1;
   localparam logic [1:0] TERM_438 = 2'h2;

   // highest full-rate current code allowed under each usb limit
   localparam logic [3:0] ICC_MAX_100 = 4'h0;
   localparam logic [3:0] ICC_MAX_500 = 4'h4;
   localparam logic [3:0] ICC_MAX_800 = 4'h7;

   // status codes
   localparam logic [2:0] ST_OFF = 3'h0;
   localparam logic [2:0] ST_PREQ = 3'h1;
   localparam logic [2:0] ST_CC = 3'h2;
   localparam logic [2:0] ST_CV = 3'h3;
   localparam logic [2:0] ST_ERR = 3'h4;
   localparam logic [2:0] ST_DONE = 3'h5;
   localparam logic [2:0] ST_TMR = 3'h6;
   localparam logic [2:0] ST_TOP = 3'h7;

   // synchronised pin count
   localparam int NSYNC = 12;

   typedef enum logic [7:0] {
      CS_OFF = 8'h01,
      CS_PREQ = 8'h02,
      CS_CC = 8'h04,
      CS_CV = 8'h08,
      CS_TOP = 8'h10,
      CS_DONE = 8'h20,
      CS_TERR = 8'h40,
      CS_TMR = 8'h80
   } csp_chg_t;

   typedef enum logic [1:0] {
      BF_OFF = 2'h0,
      BF_REG = 2'h1,
      BF_ON = 2'h2
   } csp_bfet_t;
endpackage

/* File: hw/csp_sync.sv */
`timescale 1ns/1ps
module csp_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // pins
   input wire logic [csp_pkg::NSYNC-1:0] async_in,
   output logic [csp_pkg::NSYNC-1:0] sync_out
);
   typedef struct packed {
      logic [csp_pkg::NSYNC-1:0] stage1;
      logic [csp_pkg::NSYNC-1:0] stage2;
   } csp_sync_t;

   csp_sync_t st_ff;
   csp_sync_t nxt_st;

   always_comb begin
      nxt_st.stage1 = async_in;
      nxt_st.stage2 = st_ff.stage1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.stage2;
endmodule

/* File: hw/csp_top.sv */
`timescale 1ns/1ps
module csp_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // power and usb pins
   input wire logic adapter_present,
   input wire logic usb_power_input,
   input wire logic usb_suspend_pin,
   input wire logic usb_limit_select_pin,
   // analog comparators
   input wire logic vbat_above_fullrate,
   input wire logic [2:0] vbat_below_restart,
   input wire logic vbat_at_term,
   input wire logic eoc_current,
   input wire logic temp_ok,
   input wire logic sys_over_limit,
   // charger timers
   input wire logic topoff_done,
   input wire logic safety_timeout,
   // charger and routing controls
   output logic usb_path_fet_on,
   output logic [1:0] battery_fet_mode,
   output logic usb_path_enable,
   output logic batt_supplement,
   output logic sys_from_usb,
   output logic [1:0] usb_limit_code,
   output logic [3:0] charge_current_code,
   output logic charge_active,
   output logic safety_timer_clear,
   output logic led_current_hi,
   output logic led_enable,
   output logic temp_window_45
);
   typedef struct packed {
      csp_pkg::csp_chg_t chg;
      logic [7:0] chg_ctl;
      logic led_cur;
      logic led_en;
      logic temp_win;
      logic [1:0] ilim;
      logic [7:0] rdata;
      logic usb_fet;
      csp_pkg::csp_bfet_t bfet;
      logic usb_en;
      logic supp;
      logic from_usb;
      logic [1:0] lim;
      logic [3:0] icc;
      logic active;
      logic tclr;
      logic en_prev;
   } csp_state_t;

   csp_state_t st_ff;
   csp_state_t nxt_st;
   logic [csp_pkg::NSYNC-1:0] pin_s;
   logic adp, usb_pw, susp, isel, above_fr, at_term, eoc, t_ok, over;
   logic [2:0] below;
   logic usb_on, ext, en, restart_hit;
   logic [2:0] stat;

   csp_sync u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({adapter_present, usb_power_input, usb_suspend_pin, usb_limit_select_pin,
                 vbat_above_fullrate, vbat_below_restart, vbat_at_term, eoc_current,
                 temp_ok, sys_over_limit}),
      .sync_out(pin_s)
   );

   assign {adp, usb_pw, susp, isel, above_fr, below, at_term, eoc, t_ok, over} = pin_s;

   function automatic logic [2:0] stat_code(input csp_pkg::csp_chg_t s);
      case (s)
         csp_pkg::CS_PREQ: stat_code = csp_pkg::ST_PREQ;
         csp_pkg::CS_CC: stat_code = csp_pkg::ST_CC;
         csp_pkg::CS_CV: stat_code = csp_pkg::ST_CV;
         csp_pkg::CS_TOP: stat_code = csp_pkg::ST_TOP;
         csp_pkg::CS_DONE: stat_code = csp_pkg::ST_DONE;
         csp_pkg::CS_TERR: stat_code = csp_pkg::ST_ERR;
         csp_pkg::CS_TMR: stat_code = csp_pkg::ST_TMR;
         default: stat_code = csp_pkg::ST_OFF;
      endcase
   endfunction

   // resolves the active limit from field and pin; the pin alone never reaches 800 mA
   function automatic logic [1:0] active_limit(input logic [1:0] fld, input logic pin);
      case (fld)
         csp_pkg::ILIM_PIN: active_limit = pin ? csp_pkg::ILIM_500 : csp_pkg::ILIM_100;
         default: active_limit = fld;
      endcase
   endfunction

   function automatic logic [3:0] clamp_icc(input logic [3:0] icc, input logic [3:0] cap);
      clamp_icc = (icc > cap) ? cap : icc;
   endfunction

   assign usb_on = usb_pw & ~susp;
   assign ext = adp | usb_on;
   assign en = st_ff.chg_ctl[csp_pkg::CHG_EN_BIT];
   assign stat = stat_code(st_ff.chg);

   // restart comparator chosen by termination code; reserved code falls back to 4.0V
   always_comb begin
      case (st_ff.chg_ctl[csp_pkg::TERM_LSB +: 2])
         csp_pkg::TERM_410: restart_hit = below[0];
         csp_pkg::TERM_438: restart_hit = below[2];
         default: restart_hit = below[1];
      endcase
   end

   always_comb begin
      logic [3:0] cap;
      logic chg_now;
      cap = csp_pkg::ICC_MAX_100;
      chg_now = 1'b0;
      nxt_st = st_ff;
      nxt_st.tclr = 1'b0;
      nxt_st.en_prev = en;

      // register writes; status and reserved bits have no storage
      if (reg_wr) begin
         case (reg_addr)
            csp_pkg::CHG_CTL_ADDR: nxt_st.chg_ctl = reg_wdata;
            csp_pkg::SUPV_ADDR: begin
               nxt_st.led_cur = reg_wdata[csp_pkg::LED_CUR_BIT];
               nxt_st.led_en = reg_wdata[csp_pkg::LED_EN_BIT];
               nxt_st.temp_win = reg_wdata[csp_pkg::TEMP_WIN_BIT];
            end
            csp_pkg::ILIM_ADDR: nxt_st.ilim = reg_wdata[1:0];
            default: begin
            end
         endcase
      end

      // registered read data; unmapped offsets read zero
      if (reg_rd) begin
         case (reg_addr)
            csp_pkg::CHG_CTL_ADDR: nxt_st.rdata = st_ff.chg_ctl;
            csp_pkg::SUPV_ADDR: nxt_st.rdata = {2'h0, st_ff.led_cur, st_ff.led_en, st_ff.temp_win, stat};
            csp_pkg::ILIM_ADDR: nxt_st.rdata = {6'h0, st_ff.ilim};
            default: nxt_st.rdata = 8'h00;
         endcase
      end

      // re-enabling the charger restarts the safety timer
      if (en && !st_ff.en_prev) begin
         nxt_st.tclr = 1'b1;
      end

      // charger sequence
      case (st_ff.chg)
         csp_pkg::CS_DONE: begin
            // completion holds even with enable clear; only a restart or loss of power leaves it
            if (!ext) begin
               nxt_st.chg = csp_pkg::CS_OFF;
            end else if (restart_hit && en) begin
               nxt_st.chg = csp_pkg::CS_CC;
               nxt_st.tclr = 1'b1;
            end
         end
         csp_pkg::CS_OFF: begin
            if (ext && en) begin
               nxt_st.chg = csp_pkg::CS_PREQ;
               nxt_st.tclr = 1'b1;
            end
         end
         csp_pkg::CS_TMR: begin
            // expiry is latched until power or enable goes away
            if (!ext || !en) begin
               nxt_st.chg = csp_pkg::CS_OFF;
            end
         end
         csp_pkg::CS_TERR: begin
            if (!ext || !en) begin
               nxt_st.chg = csp_pkg::CS_OFF;
            end else if (t_ok) begin
               nxt_st.chg = csp_pkg::CS_PREQ;
               nxt_st.tclr = 1'b1;
            end
         end
         default: begin
            if (!ext || !en) begin
               nxt_st.chg = csp_pkg::CS_OFF;
            end else if (!t_ok) begin
               nxt_st.chg = csp_pkg::CS_TERR;
            end else if (safety_timeout) begin
               nxt_st.chg = csp_pkg::CS_TMR;
            end else begin
               case (st_ff.chg)
                  csp_pkg::CS_PREQ: if (above_fr) nxt_st.chg = csp_pkg::CS_CC;
                  csp_pkg::CS_CC: if (at_term) nxt_st.chg = csp_pkg::CS_CV;
                  csp_pkg::CS_CV: if (eoc) nxt_st.chg = csp_pkg::CS_TOP;
                  csp_pkg::CS_TOP: if (topoff_done) nxt_st.chg = csp_pkg::CS_DONE;
                  default: nxt_st.chg = csp_pkg::CS_OFF;
               endcase
            end
         end
      endcase

      // limit follows field and pin every cycle and caps the usb charge current in the routing below
      nxt_st.lim = active_limit(st_ff.ilim, isel);
      case (nxt_st.lim)
         csp_pkg::ILIM_500: cap = csp_pkg::ICC_MAX_500;
         csp_pkg::ILIM_800: cap = csp_pkg::ICC_MAX_800;
         default: cap = csp_pkg::ICC_MAX_100;
      endcase

      chg_now = (st_ff.chg == csp_pkg::CS_PREQ) || (st_ff.chg == csp_pkg::CS_CC) ||
                (st_ff.chg == csp_pkg::CS_CV) || (st_ff.chg == csp_pkg::CS_TOP);
      nxt_st.active = chg_now;

      // power routing: adapter wins over usb
      if (adp) begin
         nxt_st.usb_fet = 1'b0;
         nxt_st.bfet = csp_pkg::BF_REG;
         nxt_st.usb_en = 1'b0;
         nxt_st.supp = 1'b0;
         nxt_st.from_usb = 1'b0;
         nxt_st.icc = st_ff.chg_ctl[csp_pkg::ICC_LSB +: 4];
      end else if (usb_on) begin
         nxt_st.usb_fet = 1'b1;
         nxt_st.usb_en = 1'b1;
         nxt_st.from_usb = above_fr;
         nxt_st.supp = over;
         nxt_st.bfet = over ? csp_pkg::BF_ON : csp_pkg::BF_REG;
         nxt_st.icc = clamp_icc(st_ff.chg_ctl[csp_pkg::ICC_LSB +: 4], cap);
      end else begin
         nxt_st.usb_fet = 1'b0;
         nxt_st.bfet = csp_pkg::BF_ON;
         nxt_st.usb_en = 1'b0;
         nxt_st.supp = 1'b0;
         nxt_st.from_usb = 1'b0;
         nxt_st.icc = st_ff.chg_ctl[csp_pkg::ICC_LSB +: 4];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_ff.chg <= csp_pkg::CS_OFF;
         st_ff.chg_ctl <= csp_pkg::CHG_CTL_RST;
         st_ff.led_cur <= csp_pkg::LED_CUR_RST;
         st_ff.led_en <= csp_pkg::LED_EN_RST;
         st_ff.temp_win <= csp_pkg::TEMP_WIN_RST;
         st_ff.ilim <= csp_pkg::ILIM_RST;
         st_ff.rdata <= 8'h00;
         st_ff.usb_fet <= 1'b0;
         st_ff.bfet <= csp_pkg::BF_ON;
         st_ff.usb_en <= 1'b0;
         st_ff.supp <= 1'b0;
         st_ff.from_usb <= 1'b0;
         st_ff.lim <= csp_pkg::ILIM_100;
         st_ff.icc <= 4'h0;
         st_ff.active <= 1'b0;
         st_ff.tclr <= 1'b0;
         st_ff.en_prev <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign usb_path_fet_on = st_ff.usb_fet;
   assign battery_fet_mode = st_ff.bfet;
   assign usb_path_enable = st_ff.usb_en;
   assign batt_supplement = st_ff.supp;
   assign sys_from_usb = st_ff.from_usb;
   assign usb_limit_code = st_ff.lim;
   assign charge_current_code = st_ff.icc;
   assign charge_active = st_ff.active;
   assign safety_timer_clear = st_ff.tclr;
   assign led_current_hi = st_ff.led_cur;
   assign led_enable = st_ff.led_en;
   assign temp_window_45 = st_ff.temp_win;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_restart_full_rate: assert property (
      st_ff.chg == csp_pkg::CS_DONE && ext && en && restart_hit |=> st_ff.chg == csp_pkg::CS_CC && st_ff.tclr)
      else $error("restart from completion did not enter full rate");
   a_done_holds: assert property (
      st_ff.chg == csp_pkg::CS_DONE && ext && !restart_hit |=> st_ff.chg == csp_pkg::CS_DONE)
      else $error("completion left without restart");
   a_adapter_route: assert property (
      adp ##1 1 |-> !usb_path_fet_on && battery_fet_mode == csp_pkg::BF_REG)
      else $error("adapter routing wrong");
   a_usb_fet_only: assert property (
      usb_path_fet_on |-> $past(usb_on) && !$past(adp))
      else $error("usb fet on outside usb charging");
   a_battery_alone: assert property (
      !adp && !usb_on |=> battery_fet_mode == csp_pkg::BF_ON && !usb_path_fet_on)
      else $error("battery not sole supply");
   a_suspend_cut: assert property (
      susp |=> !usb_path_enable && !usb_path_fet_on)
      else $error("usb path alive in suspend");
   a_pin_limit: assert property (
      st_ff.ilim == csp_pkg::ILIM_PIN |=> usb_limit_code != csp_pkg::ILIM_800)
      else $error("pin mode reached 800 mA");
   a_usb_clamp: assert property (
      usb_path_fet_on && usb_limit_code == csp_pkg::ILIM_100 |-> charge_current_code == csp_pkg::ICC_MAX_100)
      else $error("usb charge current above limit");
   a_supplement: assert property (
      usb_on && !adp && over |=> batt_supplement && battery_fet_mode == csp_pkg::BF_ON)
      else $error("battery did not supplement usb");
endmodule

/* File: verif/csp_host_model.sv */
`timescale 1ns/1ps
module csp_host_model (
   // clock
   input wire logic sys_clk,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // usb controller pins
   output logic usb_suspend_pin,
   output logic usb_limit_select_pin
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      usb_suspend_pin = 1'b0;
      usb_limit_select_pin = 1'b0;
   end
   // a spare edge before each strobe keeps every signal to one change per time step
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = addr;
      reg_wdata = data;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      // released bus shows the inverse so a stale value cannot pass
      reg_wdata = ~data;
   endtask
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = addr;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~addr;
      data = reg_rdata;
   endtask
   // the pin has two levels only, so 800 mA needs the register
   task automatic set_usb(input logic susp, input logic sel);
      @(posedge sys_clk);
      #1;
      usb_suspend_pin = susp;
      usb_limit_select_pin = sel;
   endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic adp, usb, sel, ovl;
      logic [1:0] lim;
      logic ufet;
      logic [1:0] bfet;
      logic bsup;
      logic [1:0] lcode;
      logic [3:0] icc;
   } csp_row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic adapter_present, usb_power_input, vbat_above_fullrate, vbat_at_term, eoc_current;
   logic temp_ok, sys_over_limit, topoff_done, safety_timeout;
   logic [2:0] vbat_below_restart;
   logic reg_wr, reg_rd, usb_suspend_pin, usb_limit_select_pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic usb_path_fet_on, usb_path_enable, batt_supplement, sys_from_usb, charge_active;
   logic safety_timer_clear, led_current_hi, led_enable, temp_window_45;
   logic [1:0] battery_fet_mode, usb_limit_code;
   logic [3:0] charge_current_code;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int clr_count = 0;
   int n;
   int j;
   csp_row_t rows [8];

   csp_top uut (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .adapter_present, .usb_power_input, .usb_suspend_pin, .usb_limit_select_pin,
      .vbat_above_fullrate, .vbat_below_restart, .vbat_at_term, .eoc_current, .temp_ok,
      .sys_over_limit, .topoff_done, .safety_timeout, .usb_path_fet_on, .battery_fet_mode,
      .usb_path_enable, .batt_supplement, .sys_from_usb, .usb_limit_code, .charge_current_code,
      .charge_active, .safety_timer_clear, .led_current_hi, .led_enable, .temp_window_45);
   csp_host_model host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .usb_suspend_pin, .usb_limit_select_pin);

   always #2.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (safety_timer_clear === 1'b1) begin
         clr_count <= clr_count + 1;
      end
   end

   task automatic give_verdict();
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // whole run needs about 290 cycles
   always @(posedge sys_clk) begin
      if (cycles == 20000) begin
         err_count++;
         $display("unexpected at %0t: run hung", $time);
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // pins take two edges through the synchronisers and a third to the outputs
   task automatic settle();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   task automatic stat(input logic [2:0] exp);
      settle();
      host.rd(8'h02, rv);
      chk(8'(rv[2:0]), 8'(exp));
   endtask

   initial begin
      {adapter_present, usb_power_input, vbat_above_fullrate, vbat_at_term} = 4'h0;
      {eoc_current, sys_over_limit, topoff_done, safety_timeout} = 4'h0;
      temp_ok = 1'b1;
      vbat_below_restart = 3'h0;
      rows[0] = {4'b0000, 2'h0, 1'b0, 2'h2, 1'b0, 2'h1, 4'h9};
      rows[1] = {4'b1000, 2'h0, 1'b0, 2'h1, 1'b0, 2'h1, 4'h9};
      rows[2] = {4'b0100, 2'h0, 1'b1, 2'h1, 1'b0, 2'h1, 4'h0};
      rows[3] = {4'b0110, 2'h0, 1'b1, 2'h1, 1'b0, 2'h2, 4'h4};
      rows[4] = {4'b0111, 2'h1, 1'b1, 2'h2, 1'b1, 2'h1, 4'h0};
      rows[5] = {4'b0100, 2'h2, 1'b1, 2'h1, 1'b0, 2'h2, 4'h4};
      rows[6] = {4'b0110, 2'h3, 1'b1, 2'h1, 1'b0, 2'h3, 4'h7};
      rows[7] = {4'b1110, 2'h3, 1'b0, 2'h1, 1'b0, 2'h3, 4'h9};
      repeat (4) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      vbat_above_fullrate = 1'b1;
      host.wr(csp_pkg::CHG_CTL_ADDR, 8'h67);
      foreach (rows[i]) begin
         host.wr(csp_pkg::ILIM_ADDR, {6'h00, rows[i].lim});
         host.set_usb(1'b0, rows[i].sel);
         adapter_present = rows[i].adp;
         usb_power_input = rows[i].usb;
         sys_over_limit = rows[i].ovl;
         settle();
         chk(8'(usb_path_fet_on), 8'(rows[i].ufet));
         chk(8'(battery_fet_mode), 8'(rows[i].bfet));
         chk(8'(batt_supplement), 8'(rows[i].bsup));
         chk(8'(usb_limit_code), 8'(rows[i].lcode));
         chk(8'(charge_current_code), 8'(rows[i].icc));
      end
      // second reset in mid-run
      rst_n = 1'b0;
      {adapter_present, usb_power_input, sys_over_limit} = 3'h0;
      settle();
      rst_n = 1'b1;
      chk(8'(usb_limit_code), 8'h01);
      chk(8'(charge_current_code), 8'h00);
      chk(8'(battery_fet_mode), 8'h02);
      chk(8'({led_current_hi, led_enable, temp_window_45}), 8'h06);
      host.rd(csp_pkg::CHG_CTL_ADDR, rv);
      chk(rv, 8'h47);
      host.rd(8'h02, rv);
      chk(rv, 8'h30);
      host.rd(csp_pkg::ILIM_ADDR, rv);
      chk(rv, 8'h00);
      host.wr(8'h02, 8'hff);
      host.wr(csp_pkg::ILIM_ADDR, 8'hff);
      host.wr(8'h7e, 8'hff);
      host.rd(8'h02, rv);
      chk(rv, 8'h38);
      host.rd(csp_pkg::ILIM_ADDR, rv);
      chk(rv, 8'h03);
      host.rd(8'h7e, rv);
      chk(rv, 8'h00);
      host.wr(8'h02, 8'h00);
      host.wr(csp_pkg::ILIM_ADDR, 8'h00);
      settle();
      chk(8'({led_current_hi, led_enable, temp_window_45}), 8'h00);
      usb_power_input = 1'b1;
      host.set_usb(1'b1, 1'b0);
      settle();
      chk(8'({usb_path_fet_on, usb_path_enable, battery_fet_mode}), 8'h02);
      host.set_usb(1'b0, 1'b0);
      settle();
      chk(8'({usb_path_fet_on, usb_path_enable, sys_from_usb}), 8'h07);
      vbat_above_fullrate = 1'b0;
      settle();
      chk(8'(sys_from_usb), 8'h00);
      usb_power_input = 1'b0;
      // a direct swap keeps power present, so the charger would stay in full rate
      stat(csp_pkg::ST_OFF);
      adapter_present = 1'b1;
      stat(csp_pkg::ST_PREQ);
      vbat_above_fullrate = 1'b1;
      stat(csp_pkg::ST_CC);
      for (int k = 0; k < 4; k++) begin
         // reserved termination code falls back to the 4.0V comparator
         j = (k == 3) ? 1 : k;
         host.wr(csp_pkg::CHG_CTL_ADDR, {2'(k), 6'h03});
         vbat_at_term = 1'b1;
         stat(csp_pkg::ST_CV);
         eoc_current = 1'b1;
         stat(csp_pkg::ST_TOP);
         topoff_done = 1'b1;
         stat(csp_pkg::ST_DONE);
         chk(8'(charge_active), 8'h00);
         {topoff_done, vbat_at_term, eoc_current} = 3'h0;
         if (k == 1) begin
            host.wr(csp_pkg::CHG_CTL_ADDR, 8'h45);
            vbat_below_restart = 3'h7;
            stat(csp_pkg::ST_DONE);
            vbat_below_restart = 3'h0;
            host.wr(csp_pkg::CHG_CTL_ADDR, 8'h47);
         end
         vbat_below_restart = ~(3'h1 << j);
         stat(csp_pkg::ST_DONE);
         // taken after the settle so a re-enable pulse above is not counted here
         n = clr_count;
         vbat_below_restart = 3'h1 << j;
         stat(csp_pkg::ST_CC);
         chk(8'(clr_count - n), 8'h01);
         chk(8'(charge_active), 8'h01);
         vbat_below_restart = 3'h0;
      end
      temp_ok = 1'b0;
      stat(csp_pkg::ST_ERR);
      temp_ok = 1'b1;
      stat(csp_pkg::ST_CC);
      safety_timeout = 1'b1;
      stat(csp_pkg::ST_TMR);
      safety_timeout = 1'b0;
      adapter_present = 1'b0;
      stat(csp_pkg::ST_OFF);
      give_verdict();
   end
endmodule
